// *** dv/gate_stage_model.sv ***
// Behavioural far side: bridge stage and pulled-up fault pin
`timescale 1ns/1ps
module gate_stage_model (
   input wire logic gateTri,
   input wire logic gateHigh,
   input wire logic gateLow,
   input wire logic faultN,
   output logic [1:0] mode,
   output logic faultPin,
   output logic clash
);
   // ----------------------------------------
   // Pin and bridge decode
   // ----------------------------------------
   // Pull-up on the pin: anything but a driven low reads high
   assign faultPin = (faultN === 1'b0) ? 1'b0 : 1'b1;
   // Both rails on would short the supply
   assign clash = gateHigh & gateLow;
   always_comb begin
      if (gateHigh)
         mode = 2'h2;
      else if (gateLow)
         mode = 2'h3;
      else if (gateTri)
         mode = 2'h1;
      else
         mode = 2'h0;
   end
endmodule

// *** dv/tb_motor_lock_fault_response.sv ***
// Self-checking bench for the motor lock fault response block
`timescale 1ns/1ps
module tb_motor_lock_fault_response;
   import lock_fault_pkg::*;
   localparam int UC = 2;
   localparam logic [1:0] LM [4] = '{2'h1, 2'h1, 2'h2, 2'h3};
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic lockDetect = 1'b0, posTo = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata, rd;
   logic faultN, gTri, gHigh, gLow, irq, awready, wready, bvalid, arready, rvalid, faultPin, clash;
   logic [1:0] bresp, rresp, mode, rs;
   int n_fail = 0;
   int checks = 0;

   always #20 mclk = ~mclk;

   motor_lock_fault_response #(.UNIT_CYCLES(UC)) i_dut (.mclk(mclk), .srst(srst), .lockDetect(lockDetect),
      .positionDetectTimeout(posTo), .faultIndicatorN_q(faultN), .gateTristate_q(gTri),
      .gateHighOn_q(gHigh), .gateLowOn_q(gLow), .irq_q(irq), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   gate_stage_model i_far (.gateTri(gTri), .gateHigh(gHigh), .gateLow(gLow), .faultN(faultN),
      .mode(mode), .faultPin(faultPin), .clash(clash));

   // ----------------------------------------
   // Checking and closing
   // ----------------------------------------
   task automatic summarize;
      if (n_fail == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic hang(input int n);
      if (n >= 50) begin
         chk("bus handshake", 32'h0000_0000, 32'h0000_0001);
         summarize();
      end
   endtask

   always @(posedge mclk) begin
      if (clash === 1'b1) begin
         chk("bridge rails", 32'(clash), 32'h0000_0000);
      end
   end

   // ----------------------------------------
   // Bus and stimulus tasks
   // ----------------------------------------
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge mclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         n++;
      end while (bvalid !== 1'b1 && n < 50);
      r = bresp;
      bready <= 1'b0;
      hang(n);
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge mclk);
         if (arready)
            arvalid <= 1'b0;
         n++;
      end while (rvalid !== 1'b1 && n < 50);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      hang(n);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axw(a, d, r);
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      axr(a, d, r);
      chk(nm, d, e);
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask

   task automatic pulse(input bit pos);
      @(posedge mclk);
      if (pos)
         posTo <= 1'b1;
      else
         lockDetect <= 1'b1;
      @(posedge mclk);
      posTo <= 1'b0;
      lockDetect <= 1'b0;
   endtask

   task automatic outs(input string nm, input logic [1:0] m, input logic f);
      chk({nm, " bridge"}, mode, m);
      chk({nm, " pin"}, faultPin, f);
   endtask

   task automatic clr;
      wr(ADDR_FAULT_CLEAR, 32'h0000_0001);
      tick(2);
      outs("cleared", 2'h0, 1'b1);
   endtask

   task automatic retry(input logic [3:0] code, input logic [3:0] iv, input int ms, input logic [1:0] m);
      int n;
      wr(ADDR_FAULT_SETTINGS_ONE, 32'(iv) << RETRY_INTERVAL_LSB | 32'(code) << RESPONSE_SELECT_LSB);
      pulse(1'b0);
      tick(ms * UC - 5);
      outs("retry wait", m, 1'b0);
      n = 0;
      while (mode !== 2'h0 && n < 20) begin
         tick(1);
         n++;
      end
      outs("retry release", 2'h0, 1'b1);
      pulse(1'b0);
      tick(ms * UC + 10);
      outs("past limit", m, 1'b0);
      clr();
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [1:0] r;
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      tick(1);
      outs("reset", 2'h0, 1'b1);
      chk("irq reset", irq, 1'b0);
      rdc("settings reset", ADDR_FAULT_SETTINGS_ONE, 32'h0000_0000);
      rdc("limit reset", ADDR_RETRY_LIMIT, 32'h0000_0000);
      rdc("mask reset", ADDR_INT_MASK, 32'h0000_0000);
      rdc("state reset", ADDR_STATUS, 32'h0000_0010);
      wr(ADDR_FAULT_SETTINGS_ONE, 32'h0000_07FC);
      rdc("settings back", ADDR_FAULT_SETTINGS_ONE, 32'h0000_07FC);
      axw(8'h40, 32'h0000_0001, r);
      chk("unmapped bresp", r, 2'h2);
      axr(8'h40, rd, rs);
      chk("unmapped rresp", rs, 2'h2);
      chk("unmapped rdata", rd, 32'h0000_0000);
      for (int c = 0; c < 4; c++) begin
         wr(ADDR_FAULT_SETTINGS_ONE, 32'(c) << RESPONSE_SELECT_LSB);
         pulse(1'b0);
         tick(50);
         outs("latched", LM[c], 1'b0);
         clr();
      end
      wr(ADDR_FAULT_SETTINGS_ONE, 32'h0000_0040);
      @(posedge mclk);
      lockDetect <= 1'b1;
      tick(6);
      outs("report", 2'h0, 1'b0);
      @(posedge mclk);
      lockDetect <= 1'b0;
      tick(3);
      outs("report end", 2'h0, 1'b1);
      for (int c = 9; c < 16; c++) begin
         wr(ADDR_FAULT_SETTINGS_ONE, 32'(c) << RESPONSE_SELECT_LSB);
         pulse(1'b0);
         tick(3);
         outs("disabled", 2'h0, 1'b1);
      end
      wr(ADDR_RETRY_LIMIT, 32'h0000_0001);
      retry(4'h4, 4'h0, 300, 2'h1);
      retry(4'h5, 4'h1, 500, 2'h1);
      retry(4'h6, 4'h2, 1000, 2'h2);
      retry(4'h7, 4'h3, 2000, 2'h3);
      rdc("int events", ADDR_INT_STATUS, 32'h0000_0007);
      wr(ADDR_INT_MASK, 32'h0000_000F);
      wr(ADDR_FAULT_SETTINGS_ONE, 32'h0000_0000);
      pulse(1'b1);
      tick(3);
      outs("timeout off", 2'h0, 1'b1);
      wr(ADDR_INT_STATUS, 32'h0000_000F);
      wr(ADDR_FAULT_SETTINGS_ONE, 32'h0000_0004);
      pulse(1'b1);
      tick(3);
      outs("timeout on", 2'h0, 1'b0);
      rdc("int status", ADDR_INT_STATUS, 32'h0000_0008);
      chk("irq masked", irq, 1'b0);
      wr(ADDR_INT_MASK, 32'h0000_0000);
      tick(3);
      chk("irq raised", irq, 1'b1);
      wr(ADDR_INT_STATUS, 32'h0000_0008);
      tick(3);
      chk("irq cleared", irq, 1'b0);
      clr();
      summarize();
   end
endmodule

// *** logic/motor_lock_fault_response.sv ***
// Motor lock fault response with AXI4-Lite register access
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module motor_lock_fault_response
   import lock_fault_pkg::*;
#(
   parameter int UNIT_CYCLES = CYCLES_PER_MS
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic lockDetect,
   input wire logic positionDetectTimeout,
   output logic faultIndicatorN_q,
   output logic gateTristate_q,
   output logic gateHighOn_q,
   output logic gateLowOn_q,
   output logic irq_q,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------
   // Bus write channel
   // ----------------------------------------
   logic [7:0] awAddr_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;
   logic awHave_q;
   logic wHave_q;
   logic wrEn;
   logic wrHit;

   assign wrEn = awHave_q && wHave_q && !s_axi_bvalid;
   assign wrHit = (awAddr_q == ADDR_FAULT_SETTINGS_ONE) || (awAddr_q == ADDR_RETRY_LIMIT) ||
                  (awAddr_q == ADDR_STATUS) || (awAddr_q == ADDR_INT_STATUS) ||
                  (awAddr_q == ADDR_INT_MASK) || (awAddr_q == ADDR_FAULT_CLEAR);

   always_ff @(posedge mclk) begin
      if (srst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         awHave_q <= 1'b0;
         wHave_q <= 1'b0;
         awAddr_q <= 8'h00;
         wData_q <= 32'h0000_0000;
         wStrb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awAddr_q <= s_axi_awaddr;
            awHave_q <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
            wHave_q <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wrEn) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return res;
   endfunction

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   logic [31:0] faultSettingsOne_q;
   logic [2:0] retryLimitCount_q;
   logic [NUM_EVENTS-1:0] intMask_q;
   logic [31:0] mergedData;
   logic clearFault;

   assign mergedData = mergeBytes(32'h0000_0000, wData_q, wStrb_q);
   assign clearFault = wrEn && (awAddr_q == ADDR_FAULT_CLEAR) && mergedData[0];

   always_ff @(posedge mclk) begin
      if (srst) begin
         faultSettingsOne_q <= FAULT_SETTINGS_ONE_RST;
         retryLimitCount_q <= RETRY_LIMIT_RST;
         intMask_q <= INT_MASK_RST;
      end else if (wrEn) begin
         if (awAddr_q == ADDR_FAULT_SETTINGS_ONE) begin
            faultSettingsOne_q <= mergeBytes(faultSettingsOne_q, wData_q, wStrb_q);
         end
         if (awAddr_q == ADDR_RETRY_LIMIT && wStrb_q[0]) begin
            retryLimitCount_q <= wData_q[2:0];
         end
         if (awAddr_q == ADDR_INT_MASK && wStrb_q[0]) begin
            intMask_q <= wData_q[NUM_EVENTS-1:0];
         end
      end
   end

   logic [3:0] lockRetryInterval;
   logic [3:0] lockResponseSelect;
   logic positionDetectTimeoutEnable;
   logic [13:0] intervalMs;

   assign lockRetryInterval = faultSettingsOne_q[RETRY_INTERVAL_LSB +: 4];
   assign lockResponseSelect = faultSettingsOne_q[RESPONSE_SELECT_LSB +: 4];
   assign positionDetectTimeoutEnable = faultSettingsOne_q[POS_TIMEOUT_EN_BIT];

   // Code 2 onward is whole seconds, one second per step
   always_comb begin
      unique case (lockRetryInterval)
         4'h0: intervalMs = RETRY_CODE0_MS;
         4'h1: intervalMs = RETRY_CODE1_MS;
         default: intervalMs = 14'(RETRY_STEP_MS * {10'h000, lockRetryInterval - 4'h1});
      endcase
   end

   // ----------------------------------------
   // Lock response decode
   // ----------------------------------------
   logic respLatch;
   logic respRetry;
   logic respReport;
   logic brakeHigh;
   logic brakeLow;

   always_comb begin
      respLatch = 1'b0;
      respRetry = 1'b0;
      respReport = 1'b0;
      brakeHigh = 1'b0;
      brakeLow = 1'b0;
      unique case (lockResponseSelect)
         RESP_LATCH_TRI_A, RESP_LATCH_TRI_B: respLatch = 1'b1;
         RESP_LATCH_HIGH: begin
            respLatch = 1'b1;
            brakeHigh = 1'b1;
         end
         RESP_LATCH_LOW: begin
            respLatch = 1'b1;
            brakeLow = 1'b1;
         end
         RESP_RETRY_TRI_A, RESP_RETRY_TRI_B: respRetry = 1'b1;
         RESP_RETRY_HIGH: begin
            respRetry = 1'b1;
            brakeHigh = 1'b1;
         end
         RESP_RETRY_LOW: begin
            respRetry = 1'b1;
            brakeLow = 1'b1;
         end
         RESP_REPORT: respReport = 1'b1;
         default: respReport = 1'b0;
      endcase
   end

   // ----------------------------------------
   // Fault state machine
   // ----------------------------------------
   lock_state_e state_q;
   logic [2:0] retryCnt_q;
   logic posFault_q;
   logic timerStart;
   logic timerDone;
   logic lockSeen;
   logic lockAct;
   logic limitHit;
   logic posEvent;

   assign lockAct = lockDetect && (respLatch || respRetry || respReport);
   assign lockSeen = (state_q == ST_IDLE) && lockAct;
   assign limitHit = retryCnt_q >= retryLimitCount_q;
   assign timerStart = lockSeen && respRetry && !limitHit;
   assign posEvent = positionDetectTimeout && positionDetectTimeoutEnable;

   retry_timer #(
      .UNIT_CYCLES(UNIT_CYCLES)
   ) u_timer (
      .mclk(mclk),
      .srst(srst),
      .start(timerStart),
      .intervalMs(intervalMs),
      .done_q(timerDone)
   );

   // Brake type is frozen at the lock so later config writes cannot flip the bridge
   always_ff @(posedge mclk) begin
      if (srst) begin
         state_q <= ST_IDLE;
         retryCnt_q <= 3'h0;
         gateTristate_q <= 1'b0;
         gateHighOn_q <= 1'b0;
         gateLowOn_q <= 1'b0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (lockSeen && respReport) begin
                  state_q <= ST_REPORT;
               end else if (lockSeen && (respLatch || limitHit)) begin
                  state_q <= ST_LATCHED;
                  gateTristate_q <= !brakeHigh && !brakeLow;
                  gateHighOn_q <= brakeHigh;
                  gateLowOn_q <= brakeLow;
               end else if (lockSeen) begin
                  state_q <= ST_RETRY;
                  retryCnt_q <= retryCnt_q + 3'h1;
                  gateTristate_q <= !brakeHigh && !brakeLow;
                  gateHighOn_q <= brakeHigh;
                  gateLowOn_q <= brakeLow;
               end
            end
            ST_RETRY: begin
               if (timerDone) begin
                  state_q <= ST_IDLE;
                  gateTristate_q <= 1'b0;
                  gateHighOn_q <= 1'b0;
                  gateLowOn_q <= 1'b0;
               end
            end
            ST_REPORT: begin
               if (!lockDetect) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_LATCHED: begin
               if (clearFault) begin
                  state_q <= ST_IDLE;
                  retryCnt_q <= 3'h0;
                  gateTristate_q <= 1'b0;
                  gateHighOn_q <= 1'b0;
                  gateLowOn_q <= 1'b0;
               end
            end
         endcase
      end
   end

   // Position timeout fault stays until software clears it
   always_ff @(posedge mclk) begin
      if (srst) begin
         posFault_q <= 1'b0;
      end else if (posEvent) begin
         posFault_q <= 1'b1;
      end else if (clearFault) begin
         posFault_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         faultIndicatorN_q <= 1'b1;
      end else begin
         faultIndicatorN_q <= !(lockSeen || posEvent || posFault_q ||
                                (state_q != ST_IDLE && !(state_q == ST_LATCHED && clearFault) &&
                                 !(state_q == ST_RETRY && timerDone) &&
                                 !(state_q == ST_REPORT && !lockDetect)));
      end
   end

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   logic [NUM_EVENTS-1:0] intStatus;
   logic [NUM_EVENTS-1:0] intSet;
   logic [NUM_EVENTS-1:0] intClr;

   assign intSet[INT_LOCK_SEEN] = lockSeen;
   assign intSet[INT_FAULT_LATCHED] = lockSeen && (respLatch || (respRetry && limitHit));
   assign intSet[INT_RETRY_DONE] = (state_q == ST_RETRY) && timerDone;
   assign intSet[INT_POS_TIMEOUT] = posEvent;
   assign intClr = (wrEn && awAddr_q == ADDR_INT_STATUS) ? mergedData[NUM_EVENTS-1:0] : '0;

   for (genvar g = 0; g < NUM_EVENTS; g++) begin : gen_flag
      sticky_flag u_flag (
         .mclk(mclk),
         .srst(srst),
         .setEv(intSet[g]),
         .clrEv(intClr[g]),
         .flag_q(intStatus[g])
      );
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         irq_q <= 1'b0;
      end else begin
         // A set mask bit blocks its event from the interrupt
         irq_q <= |(intStatus & ~intMask_q);
      end
   end

   // ----------------------------------------
   // Bus read channel
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         unique case (s_axi_araddr)
            ADDR_FAULT_SETTINGS_ONE: s_axi_rdata <= faultSettingsOne_q;
            ADDR_RETRY_LIMIT: s_axi_rdata <= {29'h0000_0000, retryLimitCount_q};
            ADDR_STATUS: s_axi_rdata <= {21'h00_0000, retryCnt_q, state_q, posFault_q, 3'h0};
            ADDR_INT_STATUS: s_axi_rdata <= {28'h000_0000, intStatus};
            ADDR_INT_MASK: s_axi_rdata <= {28'h000_0000, intMask_q};
            ADDR_FAULT_CLEAR: s_axi_rdata <= 32'h0000_0000;
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence idleLock;
      state_q == ST_IDLE && lockDetect;
   endsequence

   a_tristate_latch: assert property (@(posedge mclk) disable iff (srst)
      idleLock and (lockResponseSelect <= RESP_LATCH_TRI_B) |=> !faultIndicatorN_q && gateTristate_q
      && state_q == ST_LATCHED)
      else $error("tristate latch response wrong");
   a_high_latch: assert property (@(posedge mclk) disable iff (srst)
      idleLock and (lockResponseSelect == RESP_LATCH_HIGH) |=> gateHighOn_q && !gateLowOn_q)
      else $error("high-side brake latch wrong");
   a_low_latch: assert property (@(posedge mclk) disable iff (srst)
      idleLock and (lockResponseSelect == RESP_LATCH_LOW) |=> gateLowOn_q && !gateHighOn_q)
      else $error("low-side brake latch wrong");
   a_retry_count: assert property (@(posedge mclk) disable iff (srst)
      idleLock and (lockResponseSelect == RESP_RETRY_TRI_A) and !limitHit |=>
      state_q == ST_RETRY && retryCnt_q == $past(retryCnt_q) + 3'h1)
      else $error("retry not counted");
   a_high_retry: assert property (@(posedge mclk) disable iff (srst)
      idleLock and (lockResponseSelect == RESP_RETRY_HIGH) |=> gateHighOn_q && !faultIndicatorN_q)
      else $error("high-side retry brake wrong");
   a_low_limit: assert property (@(posedge mclk) disable iff (srst)
      idleLock and (lockResponseSelect == RESP_RETRY_LOW) and limitHit |=>
      state_q == ST_LATCHED && gateLowOn_q)
      else $error("low-side latch after limit wrong");
   a_report_only: assert property (@(posedge mclk) disable iff (srst)
      idleLock and (lockResponseSelect == RESP_REPORT) |=>
      !faultIndicatorN_q && !gateHighOn_q && !gateLowOn_q && !gateTristate_q)
      else $error("report mode touched output stage");
   a_lock_disabled: assert property (@(posedge mclk) disable iff (srst)
      idleLock and (lockResponseSelect > RESP_REPORT) |=> state_q == ST_IDLE)
      else $error("disabled lock detection reacted");
   a_retry_release: assert property (@(posedge mclk) disable iff (srst)
      state_q == ST_RETRY && timerDone |=> state_q == ST_IDLE && !gateTristate_q)
      else $error("retry interval end did not release");
   a_pos_enable: assert property (@(posedge mclk) disable iff (srst)
      positionDetectTimeout && !positionDetectTimeoutEnable && !posFault_q |=> !posFault_q)
      else $error("disabled position timeout raised a fault");
endmodule

// *** logic/retry_timer.sv ***
// Millisecond-based retry interval timer
`timescale 1ns/1ps
module retry_timer
   import lock_fault_pkg::*;
#(
   parameter int UNIT_CYCLES = CYCLES_PER_MS
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic start,
   input wire logic [13:0] intervalMs,
   output logic done_q
);
   logic [31:0] unitCnt_q;
   logic [13:0] msLeft_q;
   logic running_q;

   always_ff @(posedge mclk) begin
      if (srst) begin
         running_q <= 1'b0;
         unitCnt_q <= 32'h0000_0000;
         msLeft_q <= 14'h0000;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (start) begin
            running_q <= 1'b1;
            unitCnt_q <= 32'h0000_0000;
            msLeft_q <= intervalMs;
         end else if (running_q) begin
            if (unitCnt_q == 32'(UNIT_CYCLES - 1)) begin
               unitCnt_q <= 32'h0000_0000;
               if (msLeft_q == 14'h0001) begin
                  running_q <= 1'b0;
                  done_q <= 1'b1;
               end
               msLeft_q <= msLeft_q - 14'h0001;
            end else begin
               unitCnt_q <= unitCnt_q + 32'h0000_0001;
            end
         end
      end
   end

   a_done_after_run: assert property (@(posedge mclk) disable iff (srst) done_q |-> $past(running_q))
      else $error("retry timer finished without running");
endmodule

// *** logic/sticky_flag.sv ***
// Sticky event flag, set wins over clear
`timescale 1ns/1ps
module sticky_flag
   import lock_fault_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic setEv,
   input wire logic clrEv,
   output logic flag_q
);
   always_ff @(posedge mclk) begin
      if (srst) begin
         flag_q <= 1'b0;
      end else if (setEv) begin
         flag_q <= 1'b1;
      end else if (clrEv) begin
         flag_q <= 1'b0;
      end
   end

   a_set_wins: assert property (@(posedge mclk) disable iff (srst) setEv |=> flag_q)
      else $error("sticky flag lost an event");
endmodule

// *** shared/lock_fault_pkg.sv ***
// Constants and types shared by the motor lock fault response block
// Overview of operation
// - Retry interval field picks 300 ms, 500 ms, then 1 s to 14 s in 1 s steps.
// - Response codes 0 and 1 latch the fault, assert fault pin, tristate the output stage.
// - Response code 2 latches the fault, asserts fault pin, turns all high-side switches on.
// - Response code 3 latches the fault, asserts fault pin, turns all low-side switches on.
// - Codes 4 and 5 auto-clear after interval, count retries, latch tristated beyond limit.
// - Code 6 auto-clears each interval up to the limit, high-side brake, fault pin asserted.
// - Code 7 retries each interval up to the limit, then latches with low-side brake.
// - Code 8 only reports a lock on the fault pin, output stage untouched.
// - Codes 9 through F disable lock detection and raise no lock fault.
// - One bit enables the position detect timeout fault; reset value is disabled.
package lock_fault_pkg;
   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] ADDR_FAULT_SETTINGS_ONE = 8'h00;
   localparam logic [7:0] ADDR_RETRY_LIMIT = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_INT_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_INT_MASK = 8'h10;
   localparam logic [7:0] ADDR_FAULT_CLEAR = 8'h14;

   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int RETRY_INTERVAL_LSB = 7;
   localparam int RESPONSE_SELECT_LSB = 3;
   localparam int POS_TIMEOUT_EN_BIT = 2;
   localparam logic [31:0] FAULT_SETTINGS_ONE_RST = 32'h0000_0000;
   localparam logic [2:0] RETRY_LIMIT_RST = 3'h0;
   localparam logic [3:0] INT_MASK_RST = 4'h0;
   localparam int INT_LOCK_SEEN = 0;
   localparam int INT_FAULT_LATCHED = 1;
   localparam int INT_RETRY_DONE = 2;
   localparam int INT_POS_TIMEOUT = 3;
   localparam int NUM_EVENTS = 4;

   // ----------------------------------------
   // Lock response codes
   // ----------------------------------------
   localparam logic [3:0] RESP_LATCH_TRI_A = 4'h0;
   localparam logic [3:0] RESP_LATCH_TRI_B = 4'h1;
   localparam logic [3:0] RESP_LATCH_HIGH = 4'h2;
   localparam logic [3:0] RESP_LATCH_LOW = 4'h3;
   localparam logic [3:0] RESP_RETRY_TRI_A = 4'h4;
   localparam logic [3:0] RESP_RETRY_TRI_B = 4'h5;
   localparam logic [3:0] RESP_RETRY_HIGH = 4'h6;
   localparam logic [3:0] RESP_RETRY_LOW = 4'h7;
   localparam logic [3:0] RESP_REPORT = 4'h8;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ = 25_000_000;
   localparam int MS_PER_S = 1000;
   localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;
   localparam logic [13:0] RETRY_CODE0_MS = 14'h012C; // 300 ms
   localparam logic [13:0] RETRY_CODE1_MS = 14'h01F4; // 500 ms
   localparam logic [13:0] RETRY_STEP_MS = 14'h03E8;  // 1 s

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_LATCHED = 4'b0010,
      ST_RETRY = 4'b0100,
      ST_REPORT = 4'b1000
   } lock_state_e;
endpackage
